// File: csc_pkg.sv
/*
 Constants, register map and carrier types for the capacitive-sense
 configuration block. Assumes one 50 MHz clock that stands in for the
 main internal oscillator and a 32-bit APB master.
*/
package csc_pkg;

   // ----------------------------------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] CSC_CTRL_IDX = 8'ha0;
   localparam logic [7:0] CSC_CFG_IDX = 8'ha1;
   localparam logic [7:0] CSC_SW_IDX = 8'ha2;
   localparam logic [7:0] CSC_RF_IDX = 8'ha3;
   localparam logic [7:0] CSC_CNT_IDX = 8'ha4;
   localparam logic [ADDR_W-1:0] CSC_CTRL_ADDR = {2'h0, CSC_CTRL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CSC_CFG_ADDR = {2'h0, CSC_CFG_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CSC_SW_ADDR = {2'h0, CSC_SW_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CSC_RF_ADDR = {2'h0, CSC_RF_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CSC_CNT_ADDR = {2'h0, CSC_CNT_IDX, 2'h0};

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] CSC_CFG_RST = 8'h00;
   localparam logic [7:0] CSC_SW_RST = 8'h00;
   localparam logic [7:0] CSC_RF_RST = 8'h00;
   localparam logic [15:0] CSC_CTRL_RST = 16'h0000;
   localparam int CFG_CASCADE = 7;
   localparam int CFG_DIV_LSB = 5;
   localparam int CFG_HSEL = 4;
   localparam int CFG_INV = 3;
   localparam int CFG_SRC_LSB = 0;
   localparam int SW_SCALE_LSB = 6;
   localparam int SW_DIR = 5;
   localparam int SW_CONN = 4;
   localparam int SW_NEG = 3;
   localparam int SW_PROX = 2;
   localparam int SW_POS = 1;
   localparam int SW_RELAX = 0;
   localparam int RF_VSEL = 6;
   localparam int RF_MAN = 5;
   localparam int RF_EN = 4;
   localparam int RF_TC_LSB = 2;
   localparam int RF_ROUTE_LSB = 0;
   localparam int CTL_EN = 0;
   localparam int CTL_SD = 3;
   localparam int CTL_BASE_LSB = 8;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } csc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } csc_apb_rsp_t;

   typedef struct packed {
      logic sense_count_clock;
      logic timer_clock_tick;
      logic timer_on_prescaled;
      logic sense_pins_bus;
      logic sense_pins_gnd;
      logic ref_pin_bus;
      logic cap_pin_bus;
      logic relax_osc_on;
      logic cs_connect;
      logic cs_direction;
      logic [10:0] cs_level;
      logic ref_power;
      logic ref_select;
      logic ref_bus_connect;
      logic [1:0] filter_time_constant;
      logic filter_ch0;
      logic filter_ch1;
      logic filter_join;
   } csc_analog_t;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] sw;
      logic [7:0] rf;
      logic [15:0] ctl;
      logic [2:0] div;
      logic phase;
      logic [7:0] s1;
      logic [7:0] s2;
      logic rprev;
      logic [7:0] lo;
      logic [7:0] hi;
      csc_apb_rsp_t rsp;
      csc_analog_t ana;
   } csc_state_t;

endpackage

// File: csc_top.sv
/*
 Capacitive-sense configuration block: APB register file, clock divider,
 pin switching controls, analog enables and the two sense byte counters.
 Assumes pclk is the main internal oscillator and that count sources and
 the relaxation oscillator arrive asynchronously from the analog side.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module csc_top (
   input wire logic pclk, // main oscillator clock
   input wire logic presetn, // async reset, active low
   input wire csc_pkg::csc_apb_req_t apb_req, // APB request
   output csc_pkg::csc_apb_rsp_t apb_rsp, // APB answer
   input wire logic [6:0] count_sources, // count input sources 0..6
   input wire logic relaxation_osc_clock, // relaxation oscillator
   output csc_pkg::csc_analog_t analog_ctrl, // analog controls
   output logic [15:0] count_value // high and low counters
);
   import csc_pkg::*;

   csc_state_t st;
   csc_state_t nx;

   // ----------------------------------------------------------------
   // Decoded fields
   // ----------------------------------------------------------------
   logic cascade;
   logic [1:0] div_sel;
   logic hsel;
   logic [2:0] src_sel;
   logic en;
   logic sd_mode;
   logic run;
   logic [2:0] mask;
   logic tk;
   logic in_hi;
   logic relax_rise;
   logic lo_inc;
   logic hi_inc;
   logic acc;
   logic wr;
   logic mapped;
   logic [7:0] src_vec;

   assign cascade = st.cfg[CFG_CASCADE];
   assign div_sel = st.cfg[CFG_DIV_LSB +: 2];
   assign hsel = st.cfg[CFG_HSEL];
   assign src_sel = st.cfg[CFG_SRC_LSB +: 3];
   assign en = st.ctl[CTL_EN];
   assign sd_mode = st.ctl[CTL_SD];
   assign run = en && sd_mode;
   assign acc = apb_req.psel && apb_req.penable && !st.rsp.pready;
   // A write lands on the edge where the master sees pready high.
   assign wr = apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite;
   assign mapped = apb_req.paddr == CSC_CTRL_ADDR || apb_req.paddr == CSC_CFG_ADDR ||
                   apb_req.paddr == CSC_SW_ADDR || apb_req.paddr == CSC_RF_ADDR ||
                   apb_req.paddr == CSC_CNT_ADDR;

   always_comb begin
      // Divider tick: every 1, 2, 4 or 8 clocks.
      mask = 3'h0;
      case (div_sel)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         2'h3: mask = 3'h7;
         default: mask = 3'h0;
      endcase
      tk = (st.div & mask) == mask;
   end

   // Source 7 is a constant zero; the rest are synchronised copies.
   assign src_vec = {1'b0, st.s2[6:0]};
   assign in_hi = src_vec[src_sel] ^ st.cfg[CFG_INV];
   assign relax_rise = st.s2[7] && !st.rprev;
   assign lo_inc = run && tk && in_hi;

   always_comb begin
      hi_inc = 1'b0;
      if (cascade) begin
         hi_inc = lo_inc && st.lo == 8'hff;
      end else if (hsel) begin
         hi_inc = run && relax_rise && in_hi;
      end else begin
         hi_inc = lo_inc;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nx = st;
      nx.div = st.div + 3'h1;
      // Pins swap each divider tick.
      if (tk) begin
         nx.phase = !st.phase;
      end
      // Raw inputs only feed the first stage.
      nx.s1 = {relaxation_osc_clock, count_sources};
      nx.s2 = st.s1;
      nx.rprev = st.s2[7];

      // Counter configuration is writable at any time; keeping it still
      // while enabled is left to software.
      if (wr) begin
         case (apb_req.paddr)
            CSC_CTRL_ADDR: nx.ctl = apb_req.pwdata[15:0];
            CSC_CFG_ADDR: nx.cfg = apb_req.pwdata[7:0];
            CSC_SW_ADDR: nx.sw = apb_req.pwdata[7:0];
            CSC_RF_ADDR: nx.rf = apb_req.pwdata[7:0];
            default: nx.cfg = st.cfg;
         endcase
      end

      if (!en) begin
         nx.lo = 8'h00;
         nx.hi = 8'h00;
      end else begin
         nx.lo = st.lo + {7'h00, lo_inc};
         nx.hi = st.hi + {7'h00, hi_inc};
      end

      // One wait state, then pready with data and error.
      nx.rsp.pready = acc;
      nx.rsp.pslverr = acc && !mapped;
      nx.rsp.prdata = 32'h0000_0000;
      if (acc && !apb_req.pwrite) begin
         case (apb_req.paddr)
            CSC_CTRL_ADDR: nx.rsp.prdata = {16'h0000, st.ctl};
            CSC_CFG_ADDR: nx.rsp.prdata = {24'h000000, st.cfg};
            CSC_SW_ADDR: nx.rsp.prdata = {24'h000000, st.sw};
            CSC_RF_ADDR: nx.rsp.prdata = {24'h000000, st.rf};
            CSC_CNT_ADDR: nx.rsp.prdata = {16'h0000, st.hi, st.lo};
            default: nx.rsp.prdata = 32'h0000_0000;
         endcase
      end

      // Analog controls follow the registers one clock later.
      nx.ana.sense_count_clock = tk;
      nx.ana.timer_clock_tick = tk && st.sw[SW_PROX];
      nx.ana.timer_on_prescaled = sd_mode;
      nx.ana.sense_pins_bus = (st.sw[SW_NEG] || st.sw[SW_PROX]) && st.phase;
      nx.ana.sense_pins_gnd = (st.sw[SW_NEG] || st.sw[SW_PROX]) && !st.phase;
      nx.ana.ref_pin_bus = st.sw[SW_POS] && st.phase;
      nx.ana.cap_pin_bus = st.sw[SW_POS] && !st.phase;
      nx.ana.relax_osc_on = st.sw[SW_RELAX];
      nx.ana.cs_connect = st.sw[SW_CONN] || st.sw[SW_RELAX] || st.sw[SW_PROX];
      // Direction only matters while the source is in use.
      nx.ana.cs_direction = st.sw[SW_DIR] &&
                            (st.sw[SW_CONN] || st.sw[SW_PROX] || sd_mode);
      // Level is base shifted by scale: 1X, 2X, 4X, 8X.
      nx.ana.cs_level = {3'h0, st.ctl[CTL_BASE_LSB +: 8]} << st.sw[SW_SCALE_LSB +: 2];
      nx.ana.ref_power = st.rf[RF_EN];
      nx.ana.ref_select = st.rf[RF_VSEL];
      // Integration and oscillator own the bus when active.
      nx.ana.ref_bus_connect = st.rf[RF_EN] && st.rf[RF_MAN] && !st.sw[SW_RELAX] &&
                               !st.sw[SW_POS] && !st.sw[SW_NEG];
      nx.ana.filter_time_constant = st.rf[RF_TC_LSB +: 2];
      nx.ana.filter_ch0 = st.rf[RF_ROUTE_LSB +: 2] == 2'h1 ||
                          st.rf[RF_ROUTE_LSB +: 2] == 2'h3;
      nx.ana.filter_ch1 = st.rf[RF_ROUTE_LSB +: 2] == 2'h2 ||
                          st.rf[RF_ROUTE_LSB +: 2] == 2'h3;
      nx.ana.filter_join = st.rf[RF_ROUTE_LSB +: 2] == 2'h3;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign apb_rsp = st.rsp;
   assign analog_ctrl = st.ana;
   assign count_value = {st.hi, st.lo};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Eight quiet cycles after a divide-by-eight tick bring the next tick.
   sequence s_div8;
      (tk && div_sel == 2'h3) ##1 (div_sel == 2'h3 && !wr) [*8];
   endsequence

   div_by_eight_a: assert property (s_div8 |-> tk)
      else $error("divide by eight tick missing");
   clear_on_off_a: assert property (!en |=> st.lo == 8'h00 && st.hi == 8'h00)
      else $error("counters not cleared while disabled");
   cascade_wrap_a: assert property (en && cascade && lo_inc && st.lo == 8'hff
      |=> st.hi == $past(st.hi) + 8'h01 && st.lo == 8'h00)
      else $error("cascaded high byte did not advance");
   hold_no_sd_a: assert property (en && !sd_mode |=> $stable(count_value))
      else $error("counter moved outside sigma-delta mode");
   current_source_auto_a: assert property ((st.sw[SW_RELAX] || st.sw[SW_PROX]) && !wr
      |=> analog_ctrl.cs_connect)
      else $error("current source not connected");
   ref_override_a: assert property (st.rf[RF_MAN] && (st.sw[SW_RELAX] || st.sw[SW_POS])
      |=> !analog_ctrl.ref_bus_connect)
      else $error("manual reference connect not overridden");
   ref_power_a: assert property (!st.rf[RF_EN] |=> !analog_ctrl.ref_power &&
      !analog_ctrl.ref_bus_connect)
      else $error("reference buffer on while disabled");
   apb_answer_a: assert property (acc |=> apb_rsp.pready &&
      apb_rsp.pslverr == !$past(mapped))
      else $error("APB answer late or wrong error");
   pin_swap_a: assert property (st.sw[SW_POS] && tk && !wr
      |=> ##1 analog_ctrl.ref_pin_bus != $past(analog_ctrl.ref_pin_bus))
      else $error("integration pins did not alternate");

   // Register-to-output paths are one flop deep, so each output is checked
   // against the register value one cycle earlier.
   filter_route_a: assert property (1 |=> analog_ctrl.filter_join ==
      ($past(st.rf[RF_ROUTE_LSB +: 2]) == 2'h3))
      else $error("filter join does not follow routing field");
   filter_tc_a: assert property (1 |=> analog_ctrl.filter_time_constant ==
      $past(st.rf[RF_TC_LSB +: 2]))
      else $error("filter time constant does not follow field");
   ref_select_a: assert property (1 |=> analog_ctrl.ref_select ==
      $past(st.rf[RF_VSEL]))
      else $error("reference select does not follow field");
   relax_on_a: assert property (1 |=> analog_ctrl.relax_osc_on ==
      $past(st.sw[SW_RELAX]))
      else $error("relaxation oscillator enable not passed on");
   level_scale_a: assert property (1 |=> analog_ctrl.cs_level ==
      ({3'h0, $past(st.ctl[CTL_BASE_LSB +: 8])} << $past(st.sw[SW_SCALE_LSB +: 2])))
      else $error("current level not scaled from base");
   dir_idle_a: assert property (!st.sw[SW_DIR] |=> !analog_ctrl.cs_direction)
      else $error("direction set while direction bit clear");
   prox_tick_a: assert property (st.sw[SW_PROX] && tk |=> analog_ctrl.timer_clock_tick)
      else $error("timer tick missing under proximity drive");
   prox_off_a: assert property (!st.sw[SW_PROX] |=> !analog_ctrl.timer_clock_tick)
      else $error("timer tick without proximity drive");
   neg_ground_a: assert property (st.sw[SW_NEG] && !st.phase |=> analog_ctrl.sense_pins_gnd)
      else $error("sense pins not grounded in their phase");
   zero_source_a: assert property (en && src_sel == 3'h7 && !st.cfg[CFG_INV]
      |=> st.lo == $past(st.lo))
      else $error("low byte moved on the constant zero source");
   hi_relax_a: assert property (en && !cascade && hsel && !relax_rise
      |=> st.hi == $past(st.hi))
      else $error("high byte moved without a relaxation edge");
   indep_count_a: assert property (en && !cascade && !hsel
      |=> st.hi - $past(st.hi) == st.lo - $past(st.lo))
      else $error("independent byte counters diverged");

endmodule // csc_top

// File: tb.sv
/*
 Self-checking bench for the capacitive-sense configuration block.
 Assumes csc_pkg and csc_top are compiled first and APB answers in bounded time.
*/
`timescale 1ns/1ns
module tb;
   import csc_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk;
   logic presetn;
   csc_apb_req_t apb_req;
   csc_apb_rsp_t apb_rsp;
   logic [6:0] count_sources;
   logic relaxation_osc_clock;
   csc_analog_t analog_ctrl;
   logic [15:0] count_value;
   logic [31:0] lfsr;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [7:0] sw;
   logic [7:0] rf;
   logic [7:0] cf;
   int mismatches;
   int num_checks;
   int sc, tt, pb, rb;

   csc_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .count_sources(count_sources), .relaxation_osc_clock(relaxation_osc_clock),
      .analog_ctrl(analog_ctrl), .count_value(count_value));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Holds the request until pready is seen, then leaves one idle edge so that
   // the next setup never lands in the same time step as this release.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [31:0] exp, input logic err);
      int n;
      notes.push_back({~wr, err, wr ? 32'h0 : exp});
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         end_sim();
      end
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, exp, 1'b0);
   endtask

   task automatic sample32();
      sc = 0; tt = 0; pb = 0; rb = 0;
      repeat (32) begin
         @(negedge pclk);
         sc += analog_ctrl.sense_count_clock;
         tt += analog_ctrl.timer_clock_tick;
         pb += analog_ctrl.sense_pins_bus;
         rb += analog_ctrl.ref_pin_bus;
      end
   endtask

   // Counters are cleared and the configuration written only while disabled.
   task automatic run_count(input logic [7:0] c, input int k, input logic [15:0] exp);
      wr(CSC_CTRL_ADDR, 32'h0);
      wr(CSC_CFG_ADDR, {24'h0, c});
      count_sources <= c[3] ? 7'h7f : 7'h00;
      wr(CSC_CTRL_ADDR, 32'h9);
      repeat (4) @(posedge pclk);
      if (c[2:0] != 3'd7) count_sources[c[2:0]] <= ~c[3];
      repeat (k) @(posedge pclk);
      count_sources <= c[3] ? 7'h7f : 7'h00;
      repeat (4) @(posedge pclk);
      check(count_value, exp);
      rd(CSC_CNT_ADDR, {16'h0, exp});
   endtask

   // Every completed transfer is paired with the oldest note.
   always @(posedge pclk) begin
      if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
         if (notes.size() == 0) begin
            mismatches++;
         end else begin
            note = notes.pop_front();
            if (note[33]) check({apb_rsp.pslverr, apb_rsp.prdata}, note[32:0]);
            else check({apb_rsp.pslverr, 32'h0}, note[32:0]);
         end
      end
   end

   initial begin
      #(20 * 40000);
      mismatches++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      apb_req = '0;
      count_sources = 7'h00;
      relaxation_osc_clock = 1'b0;
      lfsr = 32'h4166;
      mismatches = 0;
      num_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(CSC_CFG_ADDR, 32'h0);
      rd(CSC_SW_ADDR, 32'h0);
      rd(CSC_RF_ADDR, 32'h0);
      rd(CSC_CTRL_ADDR, 32'h0);
      rd(CSC_CNT_ADDR, 32'h0);
      apb(1'b0, 12'h2a0, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h2a0, 32'h5a, 32'h0, 1'b1);
      for (int i = 0; i < 24; i++) begin
         lfsr = next_rand(lfsr);
         sw = lfsr[7:0];
         rf = lfsr[15:8];
         cf = lfsr[23:16];
         wr(CSC_SW_ADDR, lfsr);
         wr(CSC_RF_ADDR, lfsr >> 8);
         wr(CSC_CFG_ADDR, lfsr >> 16);
         wr(CSC_CTRL_ADDR, {16'h0, lfsr[31:24], 4'h0, lfsr[0], 3'h0});
         rd(CSC_SW_ADDR, {24'h0, sw});
         rd(CSC_RF_ADDR, {24'h0, rf});
         rd(CSC_CFG_ADDR, {24'h0, cf});
         check(analog_ctrl.relax_osc_on, sw[0]);
         check(analog_ctrl.cs_direction, sw[5] & (sw[4] | sw[2] | lfsr[0]));
         check(analog_ctrl.cs_connect, sw[4] | sw[0] | sw[2]);
         check(analog_ctrl.cs_level, {3'h0, lfsr[31:24]} << sw[7:6]);
         check(analog_ctrl.ref_power, rf[4]);
         check(analog_ctrl.ref_select, rf[6]);
         check(analog_ctrl.ref_bus_connect, rf[4] & rf[5] & ~(sw[0] | sw[1] | sw[3]));
         check(analog_ctrl.filter_time_constant, rf[3:2]);
         check(analog_ctrl.filter_join, rf[1:0] == 2'd3);
         if (rf[1:0] != 2'd3) check({analog_ctrl.filter_ch1, analog_ctrl.filter_ch0}, rf[1:0]);
         check(analog_ctrl.timer_on_prescaled, lfsr[0]);
      end
      for (int d = 0; d < 4; d++) begin
         wr(CSC_CFG_ADDR, {24'h0, 1'b0, d[1:0], 5'h0});
         wr(CSC_SW_ADDR, 32'h0e);
         repeat (2) @(posedge pclk);
         sample32();
         check(sc, 32 >> d);
         check(tt, 32 >> d);
         check(pb, 16);
         check(rb, 16);
      end
      wr(CSC_SW_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      sample32();
      check(tt + pb + rb, 0);
      for (int s = 0; s < 8; s++) begin
         run_count({4'h0, s[0] & (s != 7), s[2:0]}, 10 + s,
            (s == 7) ? 16'h0 : {2{8'(10 + s)}});
      end
      run_count(8'h86, 300, 16'h012c);
      // High byte on relaxation edges: four known pulses, input held high.
      wr(CSC_CTRL_ADDR, 32'h0);
      wr(CSC_CFG_ADDR, 32'h1f);
      wr(CSC_CTRL_ADDR, 32'h9);
      repeat (4) begin
         relaxation_osc_clock <= 1'b1;
         repeat (3) @(posedge pclk);
         relaxation_osc_clock <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      check(count_value[15:8], 8'h04);
      wr(CSC_CNT_ADDR, 32'hffff);
      wr(CSC_CTRL_ADDR, 32'h0);
      rd(CSC_CNT_ADDR, 32'h0);
      check(count_value, 16'h0);
      end_sim();
   end
endmodule // tb
